/* verilog/gwd_pkg.sv */
`default_nettype none

package gwd_pkg;

  // Avalon word map (byte offsets)
  localparam logic [3:0] ADDR_CONTROL_STATUS = 4'h0;
  localparam logic [3:0] ADDR_COUNTER        = 4'h4;
  localparam logic [3:0] ADDR_CONFIG         = 4'h8;

  // Control/status field positions
  localparam int BIT_GUARD_COUNTER_WE  = 7;
  localparam int BIT_COUNTER_WE        = 6;
  localparam int BIT_GUARD_REGISTER_WE = 5;
  localparam int BIT_REGISTER_WE       = 4;
  localparam int BIT_GUARD_RUN         = 3;
  localparam int BIT_RUN               = 2;
  localparam int BIT_GUARD_RESET_FLAG  = 1;
  localparam int BIT_RESET_FLAG        = 0;

  // Configuration field positions
  localparam int BIT_CLOCK_SELECT   = 0;
  localparam int BIT_MODULE_STANDBY = 1;

  // Counter reset and limit values, guard read value
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] COUNTER_MAX   = 8'hFF;
  localparam logic       GUARD_READ    = 1'b1;

  // Prescaler and reset pulse figures
  localparam int SYS_DIVIDE      = 8192;
  localparam int SUB_DIVIDE      = 32;
  localparam int RESET_OSC_CYCLES = 512;
  localparam int SYS_DIV_W  = $clog2(SYS_DIVIDE);
  localparam int SUB_DIV_W  = $clog2(SUB_DIVIDE);
  localparam int RESET_CNT_W = $clog2(RESET_OSC_CYCLES) + 1;
  localparam logic [SYS_DIV_W-1:0] SYS_DIV_LAST =
    SYS_DIV_W'(SYS_DIVIDE - 1);
  localparam logic [SUB_DIV_W-1:0] SUB_DIV_LAST =
    SUB_DIV_W'(SUB_DIVIDE - 1);
  localparam logic [RESET_CNT_W-1:0] RESET_CNT_LOAD =
    RESET_CNT_W'(RESET_OSC_CYCLES);

  // Clock source selection values
  localparam logic SELECT_SYS_CLOCK = 1'b0;
  localparam logic SELECT_SUB_CLOCK = 1'b1;

  // Writable control/status state
  typedef struct packed {
    logic counter_write_enable;
    logic register_write_enable;
    logic run_control;
    logic reset_occurred_flag;
  } gwd_ctrl_s;

  // Configuration held outside the guarded register
  typedef struct packed {
    logic module_standby;
    logic counter_clock_select;
  } gwd_cfg_s;

  typedef enum logic [1:0] {
    GWD_BUS_IDLE,
    GWD_BUS_ANSWER
  } gwd_bus_e;

endpackage

`default_nettype wire

/* verilog/gwd_prescaler.sv */
`timescale 1ns/1ns
`default_nettype none

module gwd_prescaler (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic enable_i,
  input  wire logic select_i,
  input  wire logic sub_clk_i,
  output var  logic tick_o
);

  logic [gwd_pkg::SYS_DIV_W-1:0] sys_div;
  logic [gwd_pkg::SUB_DIV_W-1:0] sub_div;
  logic                          sub_last;
  logic                          sub_rise;

  assign sub_rise = sub_clk_i & ~sub_last;

  // Sub-clock edge detect; input already synchronous
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sub_last <= 1'b0;
    end else begin
      sub_last <= sub_clk_i;
    end
  end

  // Both dividers restart while halted so the first period is whole
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sys_div <= '0;
      sub_div <= '0;
    end else if (!enable_i) begin
      sys_div <= '0;
      sub_div <= '0;
    end else begin
      sys_div <= sys_div + 1'b1;
      if (sub_rise) begin
        sub_div <= sub_div + 1'b1;
      end
    end
  end

  // One tick per divided period of the chosen source
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_o <= 1'b0;
    end else if (select_i == gwd_pkg::SELECT_SUB_CLOCK) begin
      tick_o <= enable_i & sub_rise & (sub_div == gwd_pkg::SUB_DIV_LAST);
    end else begin
      tick_o <= enable_i & (sys_div == gwd_pkg::SYS_DIV_LAST);
    end
  end

endmodule

`default_nettype wire

/* verilog/gwd_reset_pulse.sv */
`timescale 1ns/1ns
`default_nettype none

module gwd_reset_pulse (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic trigger_i,
  output var  logic reset_o
);

  logic [gwd_pkg::RESET_CNT_W-1:0] remaining;

  // Retrigger restarts the full width
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      remaining <= '0;
    end else if (trigger_i) begin
      remaining <= gwd_pkg::RESET_CNT_LOAD;
    end else if (remaining != '0) begin
      remaining <= remaining - 1'b1;
    end
  end

  // Output high for exactly the loaded count of cycles
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reset_o <= 1'b0;
    end else begin
      reset_o <= trigger_i |
                 (remaining[gwd_pkg::RESET_CNT_W-1:1] != '0); // Two or more
    end
  end

endmodule

`default_nettype wire

/* verilog/gwd_watchdog.sv */
// Function
// - 8-bit timer resets chip on overflow
// - Clock from sysclk/8192 or subclock/32
// - Preload gives 1 to 256 tick timeout
// - Counter write enable needs bit 7 zero
// - Counter loads only when write enabled
// - Register write enable needs bit 5 zero
// - Run and flag need register write enable
// - Run control needs bit 3 written zero
// - Count up while run, stop otherwise
// - Run takes written value; pin reset clears
// - Reset flag change needs bit 1 zero
// - Overflow sets reset flag
// - Flag cleared by pin or guarded write
// - Guards read 1, controls zero after reset
// - Failing bits hold, qualifying bits update
// - Module standby halts counting and the prescaler
// - Select 0 sysclk/8192, 1 subclock/32
// - Counter wraps FF to 00, resets zero
// - Reset output lasts 512 oscillator cycles
// - Counting resumes from loaded value
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
`default_nettype none

module gwd_watchdog (
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        SUB_CLK_I,
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output var  logic [31:0] AVS_READDATA_O,
  output var  logic        AVS_WAITREQUEST_O,
  output var  logic        WDT_RESET_O
);

  gwd_pkg::gwd_ctrl_s ctrl;
  gwd_pkg::gwd_cfg_s  cfg;
  gwd_pkg::gwd_bus_e  bus_state;
  logic [7:0]         watchdog_counter;
  logic               tick;
  logic               overflow;
  logic               count_enable;
  logic               bus_request;
  logic               bus_commit;
  logic               write_low_byte;
  logic               wr_ctrl;
  logic               wr_counter;
  logic               wr_config;
  logic [7:0]         wdata;
  logic [31:0]        next_readdata;
  logic               counter_write_enable;
  logic               register_write_enable;
  logic               run_control;
  logic               reset_occurred_flag;
  logic               next_counter_write_enable;
  logic               next_register_write_enable;
  logic               next_run_control;
  logic               next_reset_occurred_flag;

  // Guarded field update: bit changes only when its guard is written 0
  function automatic logic guarded(input logic current,
                                   input logic value,
                                   input logic guard_written,
                                   input logic allowed);
    if (allowed && !guard_written) begin
      guarded = value;
    end else begin
      guarded = current;
    end
  endfunction

  // Word decode on the byte address; low lane carries every field
  function automatic logic hit(input logic [3:0] address,
                               input logic [3:0] target);
    hit = (address[3:2] == target[3:2]);
  endfunction

  assign wdata          = AVS_WRITEDATA_I[7:0];
  assign bus_request    = AVS_READ_I | AVS_WRITE_I;
  assign bus_commit     = (bus_state == gwd_pkg::GWD_BUS_ANSWER);
  assign write_low_byte = AVS_WRITE_I & bus_commit & AVS_BYTEENABLE_I[0];
  assign wr_ctrl    = write_low_byte &
                      hit(AVS_ADDRESS_I, gwd_pkg::ADDR_CONTROL_STATUS);
  assign wr_counter = write_low_byte &
                      hit(AVS_ADDRESS_I, gwd_pkg::ADDR_COUNTER);
  assign wr_config  = write_low_byte &
                      hit(AVS_ADDRESS_I, gwd_pkg::ADDR_CONFIG);

  // Standby freezes counting while registers stay readable
  assign count_enable = ctrl.run_control & ~cfg.module_standby;
  assign overflow = tick & count_enable &
                    (watchdog_counter == gwd_pkg::COUNTER_MAX);

  // Every access takes one wait cycle; the answer is at the second edge
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      bus_state <= gwd_pkg::GWD_BUS_IDLE;
    end else begin
      case (bus_state)
        gwd_pkg::GWD_BUS_IDLE: begin
          if (bus_request) begin
            bus_state <= gwd_pkg::GWD_BUS_ANSWER;
          end
        end
        gwd_pkg::GWD_BUS_ANSWER: begin
          bus_state <= gwd_pkg::GWD_BUS_IDLE;
        end
        default: begin
          bus_state <= gwd_pkg::GWD_BUS_IDLE;
        end
      endcase
    end
  end

  // Waitrequest drops for the single cycle in which the answer stands
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
    end else begin
      AVS_WAITREQUEST_O <= ~((bus_state == gwd_pkg::GWD_BUS_IDLE) &
                             bus_request);
    end
  end

  // Read mux; guard bits always read 1, unmapped words read zero
  always_comb begin
    next_readdata = '0;
    if (hit(AVS_ADDRESS_I, gwd_pkg::ADDR_CONTROL_STATUS)) begin
      next_readdata[gwd_pkg::BIT_GUARD_COUNTER_WE]  = gwd_pkg::GUARD_READ;
      next_readdata[gwd_pkg::BIT_COUNTER_WE]        =
        ctrl.counter_write_enable;
      next_readdata[gwd_pkg::BIT_GUARD_REGISTER_WE] = gwd_pkg::GUARD_READ;
      next_readdata[gwd_pkg::BIT_REGISTER_WE]       =
        ctrl.register_write_enable;
      next_readdata[gwd_pkg::BIT_GUARD_RUN]         = gwd_pkg::GUARD_READ;
      next_readdata[gwd_pkg::BIT_RUN]               = ctrl.run_control;
      next_readdata[gwd_pkg::BIT_GUARD_RESET_FLAG]  = gwd_pkg::GUARD_READ;
      next_readdata[gwd_pkg::BIT_RESET_FLAG]        =
        ctrl.reset_occurred_flag;
    end else if (hit(AVS_ADDRESS_I, gwd_pkg::ADDR_COUNTER)) begin
      next_readdata[7:0] = watchdog_counter;
    end else if (hit(AVS_ADDRESS_I, gwd_pkg::ADDR_CONFIG)) begin
      next_readdata[gwd_pkg::BIT_CLOCK_SELECT]   = cfg.counter_clock_select;
      next_readdata[gwd_pkg::BIT_MODULE_STANDBY] = cfg.module_standby;
    end
  end

  // Read data captured as waitrequest falls, held until the next read answer
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      AVS_READDATA_O <= '0;
    end else if ((bus_state == gwd_pkg::GWD_BUS_IDLE) && AVS_READ_I) begin
      AVS_READDATA_O <= next_readdata;
    end
  end

  // Candidate field values for a control write; each bit is guarded on
  // its own, so one byte may set some bits and leave others. The
  // register enable used is the one held before this write, so
  // unlocking and using it always takes two separate writes
  always_comb begin
    next_counter_write_enable  = guarded(counter_write_enable,
      wdata[gwd_pkg::BIT_COUNTER_WE],
      wdata[gwd_pkg::BIT_GUARD_COUNTER_WE], 1'b1);
    next_register_write_enable = guarded(register_write_enable,
      wdata[gwd_pkg::BIT_REGISTER_WE],
      wdata[gwd_pkg::BIT_GUARD_REGISTER_WE], 1'b1);
    next_run_control           = guarded(run_control,
      wdata[gwd_pkg::BIT_RUN], wdata[gwd_pkg::BIT_GUARD_RUN],
      register_write_enable);
    next_reset_occurred_flag   = guarded(reset_occurred_flag,
      wdata[gwd_pkg::BIT_RESET_FLAG], wdata[gwd_pkg::BIT_GUARD_RESET_FLAG],
      register_write_enable);
  end

  // Counter write enable
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      counter_write_enable <= 1'b0;
    end else if (wr_ctrl) begin
      counter_write_enable <= next_counter_write_enable;
    end
  end

  // Register write enable
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      register_write_enable <= 1'b0;
    end else if (wr_ctrl) begin
      register_write_enable <= next_register_write_enable;
    end
  end

  // Run control; a guarded write or the pin reset clears it, never our own overflow
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      run_control <= 1'b0;
    end else if (wr_ctrl) begin
      run_control <= next_run_control;
    end
  end

  // Reset flag: overflow set wins over a same-cycle software clear,
  // so software always sees why the chip was reset
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      reset_occurred_flag <= 1'b0;
    end else if (overflow) begin
      reset_occurred_flag <= 1'b1;
    end else if (wr_ctrl) begin
      reset_occurred_flag <= next_reset_occurred_flag;
    end
  end

  // Fields kept as separate flops, one driver each, gathered for readers
  assign ctrl = {counter_write_enable, register_write_enable, run_control,
                 reset_occurred_flag};

  // Clock select and standby live in the plain configuration word
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cfg.counter_clock_select <= gwd_pkg::SELECT_SYS_CLOCK;
      cfg.module_standby       <= 1'b0;
    end else if (wr_config) begin
      cfg.counter_clock_select <= wdata[gwd_pkg::BIT_CLOCK_SELECT];
      cfg.module_standby       <= wdata[gwd_pkg::BIT_MODULE_STANDBY];
    end
  end

  // Counter: a load beats a tick; preload N gives 256-N ticks to overflow
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      watchdog_counter <= gwd_pkg::COUNTER_RESET;
    end else if (wr_counter && ctrl.counter_write_enable) begin
      watchdog_counter <= wdata;
    end else if (tick && count_enable) begin
      watchdog_counter <= watchdog_counter + 1'b1;
    end
  end

  // Tick source; dividers idle while stopped to save power
  gwd_prescaler u_prescaler (
    .clk_i     (SYS_CLK_I),
    .resetn_i  (RESETN_I),
    .enable_i  (count_enable),
    .select_i  (cfg.counter_clock_select),
    .sub_clk_i (SUB_CLK_I),
    .tick_o    (tick)
  );

  // Chip reset pulse; the system clock stands in for the oscillator
  gwd_reset_pulse u_reset_pulse (
    .clk_i     (SYS_CLK_I),
    .resetn_i  (RESETN_I),
    .trigger_i (overflow),
    .reset_o   (WDT_RESET_O)
  );

endmodule

`default_nettype wire

/* sim/gwd_watchdog_sva.sv */
`timescale 1ns/1ns
`default_nettype none

module gwd_watchdog_sva (
  input wire logic        SYS_CLK_I,
  input wire logic        RESETN_I,
  input wire logic [3:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  input wire logic        WDT_RESET_O
);
  logic [9:0] high_cnt;
  logic       rd_ans;

  // Pulse length so far; a counter avoids a huge repetition
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      high_cnt <= 10'h000;
    end else begin
      high_cnt <= WDT_RESET_O ? high_cnt + 10'h001 : 10'h000;
    end
  end

  // Read data stands at the answer edge
  assign rd_ans = AVS_READ_I && !AVS_WAITREQUEST_O;

  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);

  property p_take;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O;
  endproperty
  a_take: assert property (p_take) else $error("request not answered");
  property p_one_cycle;
    !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("answer too long");
  property p_idle;
    !(AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O;
  endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_guards;
    rd_ans && AVS_ADDRESS_I[3:2] == 2'h0 |->
      (AVS_READDATA_O[7:0] & 8'hAA) == 8'hAA;
  endproperty
  a_guards: assert property (p_guards)
    else $error("guard bit read 0");
  property p_unmapped;
    rd_ans && AVS_ADDRESS_I[3:2] == 2'h3 |-> AVS_READDATA_O == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_byte;
    rd_ans |-> AVS_READDATA_O[31:8] == 24'h000000;
  endproperty
  a_byte: assert property (p_byte)
    else $error("upper read bits set");
  property p_pulse_len;
    $fell(WDT_RESET_O) |-> high_cnt == 10'h200;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("pulse length");
  property p_pulse_gap;
    $fell(WDT_RESET_O) |=> !WDT_RESET_O [*8];
  endproperty
  a_pulse_gap: assert property (p_pulse_gap)
    else $error("pulse too soon");
  c_write: cover property (AVS_WRITE_I && !AVS_WAITREQUEST_O);
  c_read: cover property (rd_ans);
  c_pulse: cover property ($rose(WDT_RESET_O));
endmodule

bind gwd_watchdog gwd_watchdog_sva chk (.SYS_CLK_I(SYS_CLK_I),
  .RESETN_I(RESETN_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .WDT_RESET_O(WDT_RESET_O));

`default_nettype wire

/* sim/gwd_watchdog_bench.sv */
`timescale 1ns/1ns
`default_nettype none

module gwd_watchdog_bench;
  typedef struct packed {
    logic [3:0] wa;
    logic [7:0] wd;
    logic [3:0] be;
    logic [3:0] ra;
    logic [7:0] ex;
  } gwd_row_s;
  // Write, then read back; guards left at 1 keep their bits untouched
  localparam gwd_row_s TABLE [15] = '{
    '{4'h0, 8'hC0, 4'hF, 4'h0, 8'hAA},
    '{4'h0, 8'h6A, 4'hF, 4'h0, 8'hEA},
    '{4'h4, 8'h12, 4'hF, 4'h4, 8'h12},
    '{4'h0, 8'hA6, 4'hF, 4'h0, 8'hEA},
    '{4'h0, 8'hA9, 4'hF, 4'h0, 8'hEA},
    '{4'h0, 8'h9A, 4'hF, 4'h0, 8'hFA},
    '{4'h0, 8'hA9, 4'hF, 4'h0, 8'hFB},
    '{4'h0, 8'hA8, 4'hF, 4'h0, 8'hFA},
    '{4'h4, 8'h34, 4'h0, 4'h4, 8'h12},
    '{4'h0, 8'h2E, 4'hF, 4'h0, 8'hBA},
    '{4'h4, 8'h55, 4'hF, 4'h4, 8'h12},
    '{4'hC, 8'h77, 4'hF, 4'hC, 8'h00},
    '{4'h8, 8'h01, 4'hF, 4'h8, 8'h01},
    '{4'h0, 8'h6A, 4'hF, 4'h0, 8'hFA},
    '{4'h4, 8'hFF, 4'hF, 4'h4, 8'hFF}
  };
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        sub_clk = 1'b0;
  logic        sub_en = 1'b0;
  logic [1:0]  sub_cnt = 2'h0;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0]  be = 4'h0;
  logic [31:0] rdata;
  logic        waitreq;
  logic        wdt;
  logic [31:0] got;
  int          mismatches = 0;
  int          comparisons = 0;
  int          n;

  gwd_watchdog uut (.SYS_CLK_I(clk), .RESETN_I(rstn), .SUB_CLK_I(sub_clk),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .WDT_RESET_O(wdt));

  // System clock
  always #5 clk = ~clk;

  // Sub-clock at a quarter of the system rate, driven on the rising edge;
  // it rests at 0 while disabled so no stray edge reaches the prescaler
  always @(posedge clk) begin
    sub_cnt <= sub_cnt + 2'h1;
    sub_clk <= sub_en & sub_cnt[1];
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One bus cycle; request held until waitrequest is seen low
  task automatic bus(input logic is_rd, input logic [3:0] a,
                     input logic [7:0] d, input logic [3:0] en);
    int k;
    @(posedge clk);
    rd <= is_rd;
    wr <= ~is_rd;
    addr <= a;
    wdata <= {24'h000000, d};
    be <= en;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (waitreq === 1'b0) break;
    end
    if (k == 20) check("bus_answer", 32'h00000000, 32'h00000001);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a,
                        input logic [7:0] exp);
    bus(1'b1, a, 8'h00, 4'hF);
    check(what, {24'h000000, exp}, got);
  endtask

  // Bounded wait for the reset output to reach a level
  task automatic wait_wdt(input logic lvl);
    n = 0;
    while (wdt !== lvl && n < 20000) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic complete_run;
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Long enough for one full system-clock prescale and all bus work
  initial begin
    #400000;
    mismatches++;
    complete_run;
  end

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd_chk("status_reset", 4'h0, 8'hAA);
    rd_chk("counter_reset", 4'h4, 8'h00);
    for (int i = 0; i < 15; i++) begin
      bus(1'b0, TABLE[i].wa, TABLE[i].wd, TABLE[i].be);
      rd_chk($sformatf("row %0d", i), TABLE[i].ra,
             TABLE[i].ex);
    end
    // Standby must freeze a running counter although sub-clock edges arrive
    bus(1'b0, 4'h8, 8'h03, 4'hF);
    bus(1'b0, 4'h0, 8'hA6, 4'hF);
    rd_chk("run_set", 4'h0, 8'hFE);
    sub_en <= 1'b1;
    repeat (300) @(posedge clk);
    rd_chk("standby_hold", 4'h4, 8'hFF);
    bus(1'b0, 4'h8, 8'h01, 4'hF);
    wait_wdt(1'b1);
    sub_en <= 1'b0;
    check("sub_overflow", 32'h00000001, {31'h0, wdt});
    wait_wdt(1'b0);
    check("pulse_len", 32'h00000200, n);
    rd_chk("flag_kept", 4'h0, 8'hFF);
    rd_chk("wrapped", 4'h4, 8'h00);
    bus(1'b0, 4'h0, 8'hA0, 4'hF);
    rd_chk("stopped", 4'h0, 8'hFA);
    bus(1'b0, 4'h8, 8'h00, 4'hF);
    bus(1'b0, 4'h4, 8'hFF, 4'hF);
    bus(1'b0, 4'h0, 8'hA6, 4'hF);
    wait_wdt(1'b1);
    check("sys_tick", 32'h00000001,
          {31'h0, n > 8185 && n < 8200});
    // Pin reset in mid-pulse drops the output and clears controls
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    check("reset_drop", 32'h00000000, {31'h0, wdt});
    rstn <= 1'b1;
    rd_chk("status_pin", 4'h0, 8'hAA);
    rd_chk("config_pin", 4'h8, 8'h00);
    complete_run;
  end
endmodule

`default_nettype wire
